// >>> qsc_defines.vh
// Constants for the four-channel serial card: decode, fields, timing
`ifndef QSC_DEFINES_VH
`define QSC_DEFINES_VH

// Port address fields
`define QSC_A_BLK      7:4
`define QSC_A_HALF     3
`define QSC_A_CH       2:1
`define QSC_A_CD       0

// Mode word fields
`define QSC_M_FAC      1:0
`define QSC_M_LEN      3:2
`define QSC_M_PEN      4
`define QSC_M_EP       5
`define QSC_M_STOP     7:6
`define QSC_M_ESD      6
`define QSC_M_SCS      7

// Baud factor and stop codes
`define QSC_FAC_SYNC   2'h0
`define QSC_FAC_16X    2'h2
`define QSC_FAC_64X    2'h3
`define QSC_TOP_16X    7'h0f
`define QSC_TOP_64X    7'h3f
`define QSC_STOP_1H    2'h2
`define QSC_STOP_2     2'h3

// Command word bits
`define QSC_C_TX_ENABLE_BIT     0
`define QSC_C_DTR      1
`define QSC_C_RXE      2
`define QSC_C_SBRK     3
`define QSC_C_ER       4
`define QSC_C_RTS      5
`define QSC_C_IR       6
`define QSC_C_EH       7

// Reset values
`define QSC_MODE_RST   8'h00
`define QSC_CMD_RST    8'h00

// Clocking: system and crystal rates in MHz
`define QSC_SYS_MHZ    200
`define QSC_XTAL_MHZ   4
`define QSC_BAUD_W     8

`endif

// >>> qsc_card.v
// Four-channel serial card: port decode, data buffers, clocks, channels
//
// What this block does
// - Eight address lines, answer only own block
// - Top nibble decoded, jumper picks block
// - Bit three picks lower or upper eight
// - Bits one and two pick channel
// - Select active only with block and channel
// - Bit zero picks control or data
// - Per channel: mode/command, tx, status, rx
// - Write data passes only under output strobe
// - Read data driven only on valid read
// - Channel clock is crystal divided by two
// - Eight baud rates, jumper per channel
// - Channels programmed independently, async or sync
// - Baud factor one, sixteen or sixty-four
// - Character length five to eight bits
// - Parity, overrun and framing errors reported
// - False start bits rejected
// - Double buffered full duplex both directions
// - Sync hunt internal/external; sync fill insertion
// - Ready, empty, sync flags on pins, status
// - Odd port control/status, even port data
// - Transmit only with clear-to-send and enable
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "qsc_defines.vh"

module qsc_card
(
	// Clock and reset
	input  wire        sys_clk,
	input  wire        arst_n,
	// Processor port bus
	input  wire [7:0]  bus_addr,
	input  wire [7:0]  bus_wdata,
	input  wire        bus_wr,
	input  wire        bus_rd,
	output wire [7:0]  bus_rdata,
	output wire        bus_rdata_oe,
	// Jumpers
	input  wire [3:0]  jmp_block,
	input  wire        jmp_upper,
	input  wire [11:0] jmp_baud,
	// Serial and modem pins, one bit per channel
	input  wire [3:0]  rxd,
	input  wire [3:0]  cts_n,
	input  wire [3:0]  dsr_n,
	input  wire [3:0]  sync_in,
	output wire [3:0]  txd,
	output wire [3:0]  rts_n,
	output wire [3:0]  dtr_n,
	// Status pins
	output wire [3:0]  tx_holding_free,
	output wire [3:0]  tx_all_sent,
	output wire [3:0]  rx_char_available,
	output wire [3:0]  sync_found,
	output wire [3:0]  chan_sel_n
);

	// ****************************************
	// Local constants and helpers
	// ****************************************
	// Full-width quotient first, then cut to the counter width on purpose
	localparam integer XLAST_I = `QSC_SYS_MHZ / `QSC_XTAL_MHZ - 1;
	localparam [5:0] XLAST = XLAST_I[5:0]; // Sys cycles per crystal tick minus one
	localparam [3:0] PH_MODE = 4'h1; // Awaiting mode word
	localparam [3:0] PH_SYN1 = 4'h2; // Awaiting first sync char
	localparam [3:0] PH_SYN2 = 4'h4; // Awaiting second sync char
	localparam [3:0] PH_CMD  = 4'h8; // Command words
	localparam [2:0] TX_IDLE = 3'h1;
	localparam [2:0] TX_BIT  = 3'h2;
	localparam [2:0] TX_XST  = 3'h4; // Extra stop time
	localparam [2:0] RX_IDLE = 3'h1;
	localparam [2:0] RX_STRT = 3'h2;
	localparam [2:0] RX_DATA = 3'h4;

	// One-of-four channel decode
	function [3:0] qsc_ch_dec;
		input [1:0] a;
		begin
			qsc_ch_dec = 4'h1 << a;
		end
	endfunction

	// Data mask for a length code
	function [7:0] qsc_len_mask;
		input [1:0] l;
		begin
			qsc_len_mask = {l == 2'h3, l >= 2'h2, l >= 2'h1, 5'h1f};
		end
	endfunction

	// ****************************************
	// Jumper synchronisers
	// ****************************************
	reg  [16:0] jmp_s1_r; // First stage, read only by second
	reg  [16:0] jmp_s2_r; // Stable jumper view
	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			jmp_s1_r <= 17'h00000;
			jmp_s2_r <= 17'h00000;
		end
		else
		begin
			jmp_s1_r <= {jmp_baud, jmp_upper, jmp_block};
			jmp_s2_r <= jmp_s1_r;
		end
	end

	// ****************************************
	// Port decode
	// ****************************************
	wire       blk_hit  = (bus_addr[`QSC_A_BLK] == jmp_s2_r[3:0]);
	wire       card_hit = blk_hit && (bus_addr[`QSC_A_HALF] == jmp_s2_r[4]);
	wire [3:0] ch_hit   = card_hit ? qsc_ch_dec(bus_addr[`QSC_A_CH]) : 4'h0;
	wire       is_ctl   = bus_addr[`QSC_A_CD];
	wire       rd_hit   = bus_rd && card_hit;

	// ****************************************
	// Crystal, channel clock and baud divider
	// ****************************************
	reg  [5:0]              xcnt_r;  // Crystal period counter
	reg                     half_r;  // Divide-by-two phase
	reg                     chen_r;  // Channel clock enable
	reg  [`QSC_BAUD_W-1:0]  bcnt_r;  // Baud prescaler
	wire [7:0]              taps;    // Eight baud rates
	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			xcnt_r <= 6'h00;
			half_r <= 1'b0;
			chen_r <= 1'b0;
			bcnt_r <= {`QSC_BAUD_W{1'b0}};
		end
		else
		begin
			// Channel clock runs at half the crystal rate
			chen_r <= (xcnt_r == XLAST) && half_r;
			if (xcnt_r == XLAST)
			begin
				xcnt_r <= 6'h00;
				half_r <= ~half_r;
			end
			else
				xcnt_r <= xcnt_r + 6'h01;
			if (chen_r)
				bcnt_r <= bcnt_r + {{(`QSC_BAUD_W-1){1'b0}}, 1'b1};
		end
	end

	// Each tap halves the rate of the previous one
	genvar k;
	generate
		for (k = 0; k < 8; k = k + 1)
		begin : g_tap
			assign taps[k] = &bcnt_r[k:0];
		end
	endgenerate

	// ****************************************
	// Bus select and read data
	// ****************************************
	wire [7:0] ch_stat [0:3]; // Status word per channel
	wire [7:0] ch_rx   [0:3]; // Received char per channel
	reg  [7:0] rdata_r;
	reg        rdoe_r;
	reg  [3:0] sel_n_r;
	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata_r <= 8'h00;
			rdoe_r  <= 1'b0;
			sel_n_r <= 4'hf;
		end
		else
		begin
			// Selects only in the cycle after a strobe to our ports
			sel_n_r <= (bus_wr || bus_rd) ? ~ch_hit : 4'hf;
			rdoe_r  <= rd_hit;
			if (rd_hit)
				rdata_r <= is_ctl ? ch_stat[bus_addr[`QSC_A_CH]] : ch_rx[bus_addr[`QSC_A_CH]];
			else
				rdata_r <= 8'h00;
		end
	end
	assign bus_rdata    = rdata_r;
	assign bus_rdata_oe = rdoe_r;
	assign chan_sel_n   = sel_n_r;

	// ****************************************
	// Channels
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1)
		begin : g_ch
			reg  [3:0]  in_s1_r, in_s2_r; // Pin synchroniser
			reg  [7:0]  mode_r, cmd_r, syn1_r, syn2_r;
			reg  [3:0]  ph_r;
			reg  [7:0]  hold_r;   // Transmit holding register
			reg         hfull_r;
			reg  [11:0] tsh_r;    // Transmit shifter
			reg  [3:0]  tn_r;
			reg  [6:0]  tcnt_r;
			reg  [2:0]  txs_r;
			reg         tbit_r, txd_r, ssel_r, empty_r;
			reg  [9:0]  rsh_r;    // Receive assembly
			reg  [3:0]  ridx_r;
			reg  [6:0]  rcnt_r;
			reg  [2:0]  rxs_r;
			reg  [15:0] hsh_r;    // Hunt window
			reg         hunt_r, syn_r, rav_r, pe_r, oe_r, fe_r;
			reg  [7:0]  rbuf_r;
			// Write and read hits for this channel
			wire wr_ctl = bus_wr && ch_hit[i] && is_ctl;
			wire wr_dat = bus_wr && ch_hit[i] && !is_ctl;
			wire rd_dat = rd_hit && ch_hit[i] && !is_ctl;
			wire rd_st  = rd_hit && ch_hit[i] && is_ctl;
			wire s_rxd  = in_s2_r[0];
			wire cts_on = !in_s2_r[1];
			wire esync  = in_s2_r[3];
			wire tick   = chen_r && taps[jmp_s2_r[5+3*i +: 3]];
			wire async  = (mode_r[`QSC_M_FAC] != `QSC_FAC_SYNC);
			// Baud factor: cycles per bit minus one
			wire [6:0] ftop = (mode_r[`QSC_M_FAC] == `QSC_FAC_64X) ? `QSC_TOP_64X :
				(mode_r[`QSC_M_FAC] == `QSC_FAC_16X) ? `QSC_TOP_16X : 7'h00;
			wire [3:0]  nlen = 4'h5 + {2'h0, mode_r[`QSC_M_LEN]};
			wire [7:0]  msk  = qsc_len_mask(mode_r[`QSC_M_LEN]);
			wire        pen  = mode_r[`QSC_M_PEN];
			// Transmit frame from holding data or sync fill
			wire [7:0]  tdat = (hfull_r ? hold_r : (ssel_r ? syn2_r : syn1_r)) & msk;
			wire        tpar = (^tdat) ^ ~mode_r[`QSC_M_EP];
			wire [10:0] pone = {3'h0, msk} + 11'h001;
			wire [10:0] base = {3'h7, tdat} | {3'h0, ~msk};
			wire [10:0] frm  = pen ? ((base & ~pone) | (tpar ? pone : 11'h000)) : base;
			wire        go   = cts_on && cmd_r[`QSC_C_TX_ENABLE_BIT];
			wire        tload = tick && (txs_r == TX_IDLE) && go && (hfull_r || !async);
			// Receive checks
			wire [7:0]  rdat = rsh_r[7:0] & msk;
			wire        rpok = (((^rdat) ^ ~mode_r[`QSC_M_EP]) == rsh_r[nlen]);
			wire [3:0]  rlast = nlen + {3'h0, pen} - (async ? 4'h0 : 4'h1);
			wire        rdone = tick && (rxs_r == RX_DATA) && (rcnt_r == 7'h00)
				&& (ridx_r == rlast);
			wire [15:0] hv = hsh_r >> (5'h10 - {nlen, 1'b0});
			wire        hm = mode_r[`QSC_M_SCS] ? ((hv[15:8] >> (4'h8 - nlen)) & msk) == (syn1_r & msk)
				: (((hv[7:0] & msk) == (syn1_r & msk)) && (((hv >> nlen) & {8'h0, msk})
				== {8'h0, syn2_r & msk}));
			wire        hit_sync = (rxs_r == RX_IDLE) && hunt_r && tick
				&& (mode_r[`QSC_M_ESD] ? esync : hm);

			// Pin synchroniser and control word sequence
			always @(posedge sys_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					in_s1_r <= 4'hf;
					in_s2_r <= 4'hf;
					mode_r  <= `QSC_MODE_RST;
					cmd_r   <= `QSC_CMD_RST;
					syn1_r  <= 8'h00;
					syn2_r  <= 8'h00;
					ph_r    <= PH_MODE;
				end
				else
				begin
					in_s1_r <= {sync_in[i], dsr_n[i], cts_n[i], rxd[i]};
					in_s2_r <= in_s1_r;
					if (wr_ctl)
					begin
						case (ph_r)
							PH_MODE:
							begin
								mode_r <= bus_wdata;
								ph_r   <= (bus_wdata[`QSC_M_FAC] == `QSC_FAC_SYNC) ? PH_SYN1 : PH_CMD;
							end
							PH_SYN1:
							begin
								syn1_r <= bus_wdata;
								ph_r   <= mode_r[`QSC_M_SCS] ? PH_CMD : PH_SYN2;
							end
							PH_SYN2:
							begin
								syn2_r <= bus_wdata;
								ph_r   <= PH_CMD;
							end
							default:
							begin
								// Internal reset returns to mode word
								if (bus_wdata[`QSC_C_IR])
								begin
									ph_r  <= PH_MODE;
									cmd_r <= `QSC_CMD_RST;
								end
								else
									cmd_r <= bus_wdata;
							end
						endcase
					end
				end
			end

			// Transmitter: holding register feeds shifter
			always @(posedge sys_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					hold_r <= 8'h00;
					hfull_r <= 1'b0;
					tsh_r  <= 12'hfff;
					tn_r   <= 4'h0;
					tcnt_r <= 7'h00;
					txs_r  <= TX_IDLE;
					tbit_r <= 1'b1;
					txd_r  <= 1'b1;
					ssel_r <= 1'b0;
					empty_r <= 1'b1;
				end
				else
				begin
					// Break holds the line low
					txd_r   <= tbit_r && !cmd_r[`QSC_C_SBRK];
					empty_r <= (txs_r == TX_IDLE) && !hfull_r;
					if (tload)
					begin
						// Async adds start and stop; sync sends raw bits
						tsh_r  <= async ? {frm, 1'b0} : {1'b1, frm};
						tn_r   <= nlen + {3'h0, pen} + (async ? 4'h2 : 4'h0);
						tcnt_r <= 7'h00;
						txs_r  <= TX_BIT;
						if (!hfull_r && !mode_r[`QSC_M_SCS])
							ssel_r <= ~ssel_r;
						else
							ssel_r <= 1'b0;
					end
					else if (tick && (txs_r == TX_BIT))
					begin
						if (tcnt_r != 7'h00)
							tcnt_r <= tcnt_r - 7'h01;
						else if (tn_r != 4'h0)
						begin
							tbit_r <= tsh_r[0];
							tsh_r  <= {1'b1, tsh_r[11:1]};
							tn_r   <= tn_r - 4'h1;
							tcnt_r <= ftop;
						end
						else if (async && (mode_r[`QSC_M_STOP] == `QSC_STOP_1H))
						begin
							tcnt_r <= {1'b0, ftop[6:1]};
							txs_r  <= TX_XST;
						end
						else if (async && (mode_r[`QSC_M_STOP] == `QSC_STOP_2))
						begin
							tcnt_r <= ftop;
							txs_r  <= TX_XST;
						end
						else
							txs_r <= TX_IDLE;
					end
					else if (tick && (txs_r == TX_XST))
					begin
						if (tcnt_r != 7'h00)
							tcnt_r <= tcnt_r - 7'h01;
						else
							txs_r <= TX_IDLE;
					end
					else if (tick && (txs_r == TX_IDLE))
						tbit_r <= 1'b1;
					// New write beats the load that empties the holder
					if (tload && hfull_r)
						hfull_r <= 1'b0;
					if (wr_dat)
					begin
						hold_r  <= bus_wdata;
						hfull_r <= 1'b1;
					end
				end
			end

			// Receiver: start check, assembly, hunt and flags
			always @(posedge sys_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					rsh_r  <= 10'h000;
					ridx_r <= 4'h0;
					rcnt_r <= 7'h00;
					rxs_r  <= RX_IDLE;
					hsh_r  <= 16'h0000;
					hunt_r <= 1'b0;
					syn_r  <= 1'b0;
					rbuf_r <= 8'h00;
					rav_r  <= 1'b0;
					pe_r   <= 1'b0;
					oe_r   <= 1'b0;
					fe_r   <= 1'b0;
				end
				else
				begin
					if (!cmd_r[`QSC_C_RXE] || ph_r != PH_CMD)
						rxs_r <= RX_IDLE;
					else if (async && tick && (rxs_r == RX_IDLE) && !s_rxd)
					begin
						rxs_r  <= RX_STRT;
						rcnt_r <= {1'b0, ftop[6:1]};
					end
					else if (tick && (rxs_r == RX_STRT))
					begin
						if (rcnt_r != 7'h00)
							rcnt_r <= rcnt_r - 7'h01;
						else if (!s_rxd)
						begin
							rxs_r  <= RX_DATA;
							rcnt_r <= ftop;
							ridx_r <= 4'h0;
						end
						else
							rxs_r <= RX_IDLE;
					end
					else if (hit_sync || (!async && !hunt_r && rxs_r == RX_IDLE && tick))
					begin
						rxs_r  <= RX_DATA;
						rcnt_r <= 7'h00;
						ridx_r <= 4'h0;
					end
					else if (tick && (rxs_r == RX_DATA))
					begin
						if (rcnt_r != 7'h00)
							rcnt_r <= rcnt_r - 7'h01;
						else
						begin
							rsh_r[ridx_r] <= s_rxd;
							ridx_r <= ridx_r + 4'h1;
							rcnt_r <= ftop;
							if (rdone)
								rxs_r <= RX_IDLE;
						end
					end
					// Hunt shifts in every bit until a match
					if (tick && hunt_r && !async)
						hsh_r <= {s_rxd, hsh_r[15:1]};
					if (hit_sync)
						hunt_r <= 1'b0;
					if (wr_ctl && (ph_r == PH_CMD) && bus_wdata[`QSC_C_EH] && !async)
						hunt_r <= 1'b1;
					// Flags: hardware set wins over clear
					if (rd_dat)
						rav_r <= 1'b0;
					if (rd_st)
						syn_r <= 1'b0;
					if (wr_ctl && (ph_r == PH_CMD) && bus_wdata[`QSC_C_ER])
					begin
						pe_r <= 1'b0;
						oe_r <= 1'b0;
						fe_r <= 1'b0;
					end
					if (hit_sync)
						syn_r <= 1'b1;
					if (rdone)
					begin
						rbuf_r <= rdat;
						rav_r  <= 1'b1;
						if (rav_r && !rd_dat)
							oe_r <= 1'b1;
						if (pen && !rpok)
							pe_r <= 1'b1;
						if (async && !s_rxd)
							fe_r <= 1'b1;
					end
				end
			end

			// Status word and pins
			assign ch_stat[i] = {!in_s2_r[2], syn_r, fe_r, oe_r, pe_r, empty_r,
				rav_r, !hfull_r};
			assign ch_rx[i]   = rbuf_r;
			assign txd[i]     = txd_r;
			assign rts_n[i]   = !cmd_r[`QSC_C_RTS];
			assign dtr_n[i]   = !cmd_r[`QSC_C_DTR];
			assign tx_holding_free[i]   = !hfull_r;
			assign tx_all_sent[i]       = empty_r;
			assign rx_char_available[i] = rav_r;
			assign sync_found[i]        = syn_r;
		end
	endgenerate

endmodule // qsc_card
`default_nettype wire

// >>> qsc_card_properties.sv
// Concurrent checks on port decode, selects and read drive of the card
`timescale 1ns/1ps
`default_nettype none
module qsc_card_properties
(
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       arst_n,
	// Processor port bus
	input wire logic [7:0] bus_addr,
	input wire logic       bus_wr,
	input wire logic       bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic       bus_rdata_oe,
	// Jumpers and selects
	input wire logic [3:0] jmp_block,
	input wire logic       jmp_upper,
	input wire logic [3:0] chan_sel_n
);
	// ****************
	// Helper logic
	// ****************
	wire        blk_ok  = (bus_addr[7:4] == jmp_block);	// Block of sixteen hit
	wire        half_ok = (bus_addr[3] == jmp_upper);	// Right eight of sixteen
	wire        strobe  = bus_wr | bus_rd;	// Any transfer
	logic [1:0] ch_q;	// Channel of the previous cycle

	// Keep the channel field so the select can be judged one cycle later
	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			ch_q <= 2'h0;
		else
			ch_q <= bus_addr[2:1];

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// ****************
	// Sequences and assertions
	// ****************
	sequence s_card_hit;
		strobe && blk_ok && half_ok;
	endsequence
	sequence s_card_read;
		bus_rd && blk_ok && half_ok;
	endsequence

	chk_sel_onehot: assert property (s_card_hit |=> chan_sel_n == ~(4'h1 << ch_q))
		else $error("select does not match addressed channel");
	chk_block_miss: assert property (strobe && !blk_ok |=> chan_sel_n == 4'hf)
		else $error("select taken for foreign block");
	chk_half_miss: assert property (strobe && !half_ok |=> chan_sel_n == 4'hf)
		else $error("select taken for wrong half");
	chk_idle_sel: assert property (!strobe |=> chan_sel_n == 4'hf)
		else $error("select active without strobe");
	chk_read_drive: assert property (s_card_read |=> bus_rdata_oe)
		else $error("card read not driven");
	chk_drive_once: assert property ((s_card_read ##1 !bus_rd) |=> !bus_rdata_oe)
		else $error("read drive held too long");
	chk_rdata_quiet: assert property (!bus_rdata_oe |-> bus_rdata == 8'h00)
		else $error("read data present while undriven");
	chk_sel_single: assert property ($countones(~chan_sel_n) <= 1)
		else $error("more than one channel selected");
endmodule // qsc_card_properties

bind qsc_card qsc_card_properties u_props
(
	.sys_clk      (sys_clk),
	.arst_n       (arst_n),
	.bus_addr     (bus_addr),
	.bus_wr       (bus_wr),
	.bus_rd       (bus_rd),
	.bus_rdata    (bus_rdata),
	.bus_rdata_oe (bus_rdata_oe),
	.jmp_block    (jmp_block),
	.jmp_upper    (jmp_upper),
	.chan_sel_n   (chan_sel_n)
);
`default_nettype wire

// >>> qsc_far_end.sv
// Far-end terminal model: echoes each transmit line into its receiver
`timescale 1ns/1ps
`default_nettype none
module qsc_far_end
(
	// Serial lines
	input  wire logic [3:0] txd,
	output logic      [3:0] rxd,
	// Modem handshake from the terminal
	output logic      [3:0] cts_n,
	output logic      [3:0] dsr_n,
	output logic      [3:0] sync_in
);
	// Echo wire, so transmit and receive run at once
	assign rxd = txd;
	// Channel one is held off; its transmitter has to stay quiet
	assign cts_n = 4'h2;
	assign dsr_n = 4'h0;	// Terminal ready everywhere
	assign sync_in = 4'h0;	// No external sync
endmodule // qsc_far_end
`default_nettype wire

// >>> qsc_card_test.sv
// Self-checking bench for the four-channel serial card
`timescale 1ns/1ps
`default_nettype none
module qsc_card_test;
	// ****************
	// Signals
	// ****************
	logic       sys_clk;	// 200 MHz
	logic       arst_n;	// Async reset
	logic [7:0] bus_addr;	// Port address
	logic [7:0] bus_wdata;	// Write data
	logic       bus_wr;	// Output strobe
	logic       bus_rd;	// Read strobe
	wire  [7:0] bus_rdata;	// Read data
	wire        bus_rdata_oe;	// Read drive
	wire  [3:0] rxd, cts_n, dsr_n, sync_in, txd, rts_n, dtr_n;	// Serial pins
	wire  [3:0] tx_holding_free, tx_all_sent, rx_char_available, sync_found, chan_sel_n;
	int         mismatches;	// Failed compares
	int         samples_checked;	// Compares made
	int         cycles;	// Watchdog
	logic [7:0] rd_val;	// Last read data
	logic       rd_oe;	// Last read drive
	logic [3:0] sel_seen;	// Selects after a strobe
	localparam logic [7:0] base_port = 8'h58;	// Block 5, upper half
	localparam int cycle_limit = 90000;	// One frame at 16x is about 32k

	qsc_card u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.bus_rdata_oe(bus_rdata_oe), .jmp_block(4'h5), .jmp_upper(1'b1),
		.jmp_baud(12'h000), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .sync_in(sync_in),
		.txd(txd), .rts_n(rts_n), .dtr_n(dtr_n), .tx_holding_free(tx_holding_free),
		.tx_all_sent(tx_all_sent), .rx_char_available(rx_char_available),
		.sync_found(sync_found), .chan_sel_n(chan_sel_n));
	qsc_far_end u_far (.txd(txd), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n),
		.sync_in(sync_in));

	// ****************
	// Clock, watchdog and tasks
	// ****************
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Cut a hang short
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == cycle_limit)
		begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One-cycle write; selects sampled in the answer cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
		#1 sel_seen = chan_sel_n;
	endtask
	// One-cycle read; data stand only in the next cycle
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1 rd_val = bus_rdata;
		rd_oe = bus_rdata_oe;
		sel_seen = chan_sel_n;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ****************
	// Main sequence
	// ****************
	initial
	begin
		arst_n = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		mismatches = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 check({4'h0, chan_sel_n}, 8'h0f);
		check({4'h0, txd}, 8'h0f);
		check({4'h0, tx_holding_free}, 8'h0f);
		check({4'h0, rx_char_available}, 8'h00);
		$display("test reset done");
		// Software reset on every channel, one select per write
		for (int c = 0; c < 4; c++)
		begin
			for (int k = 0; k < 5; k++)
			begin
				wr(base_port | 8'(2 * c + 1), (k == 4) ? 8'h40 : 8'h01);
				check({4'h0, sel_seen}, ~(8'h01 << c) & 8'h0f);
			end
		end
		$display("test decode done");
		// Foreign block and wrong half are ignored
		for (int i = 0; i < 2; i++)
		begin
			wr(i ? 8'h51 : 8'h69, 8'h40);
			check({4'h0, sel_seen}, 8'h0f);
			rd(i ? 8'h51 : 8'h69);
			check(rd_val, 8'h00);
			check({7'h0, rd_oe}, 8'h00);
		end
		$display("test miss done");
		// 16x, eight bits, one stop; tx, rx and RTS on; channel one lacks CTS
		for (int c = 1; c >= 0; c--)
		begin
			wr(base_port | 8'(2 * c + 1), 8'h4e);
			wr(base_port | 8'(2 * c + 1), 8'h25);
			wr(base_port | 8'(2 * c), c ? 8'h3c : 8'ha5);
		end
		for (int n = 0; n < 50000 && rx_char_available[0] !== 1'b1; n++)
			@(posedge sys_clk);
		rd(base_port | 8'h01);
		check(rd_val & 8'hfb, 8'h83);
		check({7'h0, rd_oe}, 8'h01);
		check({4'h0, sel_seen}, 8'h0e);
		rd(base_port | 8'h00);
		check(rd_val, 8'ha5);
		#1 check({7'h0, rx_char_available[0]}, 8'h00);
		check({7'h0, txd[1]}, 8'h01);
		check({7'h0, tx_all_sent[1]}, 8'h00);
		check({4'h0, rts_n}, 8'h0c);
		check({4'h0, dtr_n}, 8'h0f);
		check({4'h0, sync_found}, 8'h00);
		$display("test loopback done");
		tally_and_finish();
	end
endmodule // qsc_card_test
`default_nettype wire
